// ===== verilog/ccrp_regs.sv
// register bank: strobe capture, full-scale range, power mode, timestamp and ref output
// assumes a serial control port on pins (clock, select, data in, data out)
// Notes on behaviour
// R01 - a 24-bit read-only status shows where the strobe edge landed against the clock
// R02 - software picks the strobe delay tap from the captured position it reads
// R03 - a 4-bit strobe delay select field picks the internal sampling tap
// R04 - 16-bit full-scale code for all channels, reset 0xA000 meaning 800 mVPP
// R05 - software keeps the full-scale code at or above 0x2000; 0xFFFF is the maximum
// R06 - power code 0x46 is low power, reset 0x4B is high performance, others reserved
// R07 - low-power code only when sampling rate is at most 1 GSPS
// R08 - software writes all four power mode registers together as one set
// R09 - software clears calibration and serial link enables before a new power code
// R10 - software runs calibration after any change of power mode
// R11 - timestamp control bit 0 enables the timestamp receiver, reset 0
// R12 - reference clock output runs only with its enable and the synthesizer enable
// R13 - reference output enable resets to 1 so it runs without serial writes
// R14 - software writes reset defaults into reserved bits
// R15 - writes to the strobe position status are ignored
`timescale 1ns/1ps
`default_nettype none
module ccrp_regs
   import ccrp_pkg::*;
(
   // clock, reset, enable
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        clk_en,
   // serial control port pins
   input  wire logic        spi_sclk,
   input  wire logic        spi_cs_n,
   input  wire logic        spi_sdi,
   output logic             spi_sdo,
   output logic             spi_sdo_oe,
   // strobe window detector (same clock)
   input  wire logic [23:0] strobe_window_status,
   input  wire logic        strobe_window_valid,
   // synthesizer state
   input  wire logic        synth_enable,
   // analog controls
   output logic      [3:0]  strobe_delay_select,
   output logic      [15:0] full_scale_range,
   output logic      [7:0]  power_mode_code,
   output logic             power_low_mode,
   output logic             timestamp_receiver_enable,
   output logic             timestamp_pecl_mode,
   output logic             reference_clock_output,
   output logic      [7:0]  synth_feedback_divider_first
);

   typedef struct packed {
      ccrp_phase_type phase;
      logic [3:0]     bit_cnt;
      logic           rd;
      logic [14:0]    addr;
      logic [7:0]     in_sh;
      logic [7:0]     out_sh;
      logic           sclk_q;
      logic           sdo;
      logic           sdo_oe;
      logic [7:0]     strobe_ctrl;
      logic [23:0]    pos;
      logic [15:0]    fsr;
      logic [7:0]     power;
      logic [7:0]     timestamp_input;
      logic [7:0]     refo;
      logic [7:0]     fbdiv;
      logic           refo_out;
      logic           low_mode;
   } ccrp_state_type;

   localparam ccrp_state_type RESET_STATE = '{
      phase:       CCRP_IDLE,
      bit_cnt:     4'h0,
      rd:          1'b0,
      addr:        15'h0000,
      in_sh:       8'h00,
      out_sh:      8'h00,
      sclk_q:      1'b0,
      sdo:         1'b0,
      sdo_oe:      1'b0,
      strobe_ctrl: RST_STROBE_CTRL,
      pos:         RST_POS,
      fsr:         RST_FSR,
      power:       RST_POWER,
      timestamp_input:       RST_TIMESTAMP_INPUT,
      refo:        RST_REFO,
      fbdiv:       RST_FBDIV,
      refo_out:    1'b0,
      low_mode:    1'b0
   };

   ccrp_state_type r;
   ccrp_state_type next_r;
   logic [2:0]     pins;
   logic           sclk_s;
   logic           cs_n_s;
   logic           sdi_s;

   // pin synchronisers for the serial port; select travels inverted so that
   // the synchroniser's reset level reads as deselected, not as a frame start
   ccrp_pin_sync #(
      .WIDTH (3)
   ) u_sync (
      .clk       (clk),
      .reset_n   (reset_n),
      .clk_en    (clk_en),
      .pin_in    ({spi_sclk, ~spi_cs_n, spi_sdi}),
      .level_out (pins)
   );

   assign sclk_s = pins[2];
   assign cs_n_s = ~pins[1];
   assign sdi_s  = pins[0];

   // read mux over the byte map; unmapped bytes read zero
   function automatic logic [7:0] read_byte(input ccrp_state_type s, input logic [14:0] a);
      logic [7:0] d;
      d = 8'h00;
      unique case (a)
         ADDR_STROBE_CTRL: d = s.strobe_ctrl;
         ADDR_POS_HI:      d = s.pos[23:16];  // [R01]
         ADDR_POS_MID:     d = s.pos[15:8];   // [R01]
         ADDR_POS_LO:      d = s.pos[7:0];    // [R01]
         ADDR_FSR_HI:      d = s.fsr[15:8];
         ADDR_FSR_LO:      d = s.fsr[7:0];
         ADDR_POWER_FIRST: d = s.power;
         ADDR_TIMESTAMP_INPUT_CONTROL:  d = s.timestamp_input;
         ADDR_REFO_CTRL:   d = s.refo;
         ADDR_FBDIV_FIRST: d = s.fbdiv;
         default:          d = 8'h00;
      endcase
      return d;
   endfunction : read_byte

   // next-state logic: serial port, register writes, capture, output decode
   always_comb begin
      logic       rise;
      logic       fall;
      logic [7:0] wbyte;
      next_r = r;
      rise   = sclk_s & ~r.sclk_q;
      fall   = ~sclk_s & r.sclk_q;
      wbyte  = {r.in_sh[6:0], sdi_s};
      next_r.sclk_q = sclk_s;

      // position capture from the window detector [R01]
      if (strobe_window_valid) begin
         next_r.pos = strobe_window_status;
      end

      if (cs_n_s) begin
         // deselected: abort any frame, release data out
         next_r.phase   = CCRP_IDLE;
         next_r.bit_cnt = 4'h0;
         next_r.sdo_oe  = 1'b0;
      end else begin
         unique case (r.phase)
            CCRP_IDLE: begin
               next_r.phase   = CCRP_CMD;
               next_r.bit_cnt = 4'h0;
               next_r.rd      = 1'b0;
            end
            CCRP_CMD: begin
               if (rise) begin
                  next_r.bit_cnt = r.bit_cnt + 4'h1;
                  if (r.bit_cnt == 4'h0) begin
                     next_r.rd = sdi_s;
                  end else begin
                     next_r.addr = {r.addr[13:0], sdi_s};
                  end
                  if (r.bit_cnt == 4'(CMD_LAST)) begin
                     next_r.phase   = CCRP_DATA;
                     next_r.bit_cnt = 4'h0;
                     next_r.out_sh  = read_byte(r, {r.addr[13:0], sdi_s});
                  end
               end
            end
            CCRP_DATA: begin
               if (fall && r.rd) begin
                  next_r.sdo    = r.out_sh[7];
                  next_r.sdo_oe = 1'b1;
                  next_r.out_sh = {r.out_sh[6:0], 1'b0};
               end
               if (rise) begin
                  next_r.in_sh   = wbyte;
                  next_r.bit_cnt = r.bit_cnt + 4'h1;
                  if (r.bit_cnt == 4'(BYTE_LAST)) begin
                     // byte done: write if requested, step address, prefetch next
                     next_r.bit_cnt = 4'h0;
                     next_r.addr    = r.addr + 15'h0001;
                     next_r.out_sh  = read_byte(r, r.addr + 15'h0001);
                     if (!r.rd) begin
                        unique case (r.addr)
                           ADDR_STROBE_CTRL: next_r.strobe_ctrl = wbyte;  // [R03]
                           ADDR_FSR_HI:      next_r.fsr[15:8]   = wbyte;  // [R04]
                           ADDR_FSR_LO:      next_r.fsr[7:0]    = wbyte;  // [R04]
                           ADDR_POWER_FIRST: next_r.power       = wbyte;  // [R06]
                           ADDR_TIMESTAMP_INPUT_CONTROL:  next_r.timestamp_input       = wbyte;  // [R11]
                           ADDR_REFO_CTRL:   next_r.refo        = wbyte;  // [R13]
                           ADDR_FBDIV_FIRST: next_r.fbdiv       = wbyte;
                           // position bytes and unmapped bytes take no write [R15]
                           default:          next_r.in_sh       = wbyte;
                        endcase
                     end
                  end
               end
            end
            default: begin
               next_r.phase = CCRP_IDLE;
            end
         endcase
      end

      // decoded outputs; reserved power codes leave high performance in force
      next_r.low_mode = (next_r.power == POWER_LOW);                              // [R06]
      next_r.refo_out = next_r.refo[REFO_EN_BIT] & synth_enable;                 // [R12]
   end

   // state register, frozen while the clock enable is low
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         r <= RESET_STATE;
      end else if (clk_en) begin
         r <= next_r;
      end
   end

   // outputs straight from the state register
   assign spi_sdo                      = r.sdo;
   assign spi_sdo_oe                   = r.sdo_oe;
   assign strobe_delay_select          = r.strobe_ctrl[SEL_MSB:0];   // [R03]
   assign full_scale_range             = r.fsr;                      // [R04]
   assign power_mode_code              = r.power;                    // [R06]
   assign power_low_mode               = r.low_mode;                 // [R06]
   assign timestamp_receiver_enable    = r.timestamp_input[TIMESTAMP_INPUT_RECV_BIT];    // [R11]
   assign timestamp_pecl_mode          = r.timestamp_input[TIMESTAMP_INPUT_PECL_BIT];
   assign reference_clock_output       = r.refo_out;                 // [R12]
   assign synth_feedback_divider_first = r.fbdiv;

endmodule : ccrp_regs
`default_nettype wire

// ===== verilog/ccrp_pkg.sv
// package for the clock, range and power register bank
// assumes a byte-addressed serial control port with 15-bit addresses
package ccrp_pkg;

   // serial frame layout
   localparam int unsigned ADDR_WIDTH   = 15;
   localparam int unsigned BYTE_WIDTH   = 8;
   localparam int unsigned CMD_BITS     = 16;
   localparam int unsigned CMD_LAST     = 15;
   localparam int unsigned BYTE_LAST    = 7;

   // byte addresses (multi-byte registers: most significant byte first)
   localparam logic [14:0] ADDR_STROBE_CTRL = 15'h0029;
   localparam logic [14:0] ADDR_POS_HI      = 15'h002C;
   localparam logic [14:0] ADDR_POS_MID     = 15'h002D;
   localparam logic [14:0] ADDR_POS_LO      = 15'h002E;
   localparam logic [14:0] ADDR_FSR_HI      = 15'h0030;
   localparam logic [14:0] ADDR_FSR_LO      = 15'h0031;
   localparam logic [14:0] ADDR_POWER_FIRST = 15'h0037;
   localparam logic [14:0] ADDR_TIMESTAMP_INPUT_CONTROL  = 15'h003B;
   localparam logic [14:0] ADDR_REFO_CTRL   = 15'h003C;
   localparam logic [14:0] ADDR_FBDIV_FIRST = 15'h003D;

   // reset values
   localparam logic [7:0]  RST_STROBE_CTRL = 8'h80;
   localparam logic [23:0] RST_POS         = 24'h000000;
   localparam logic [15:0] RST_FSR         = 16'hA000;
   localparam logic [7:0]  RST_POWER       = 8'h4B;
   localparam logic [7:0]  RST_TIMESTAMP_INPUT       = 8'h00;
   localparam logic [7:0]  RST_REFO        = 8'h01;
   localparam logic [7:0]  RST_FBDIV       = 8'h00;

   // power mode codes
   localparam logic [7:0]  POWER_LOW       = 8'h46;
   localparam logic [7:0]  POWER_HIGH      = 8'h4B;

   // field positions
   localparam int unsigned SEL_MSB         = 3;
   localparam int unsigned TIMESTAMP_INPUT_RECV_BIT  = 0;
   localparam int unsigned TIMESTAMP_INPUT_PECL_BIT  = 1;
   localparam int unsigned REFO_EN_BIT     = 0;

   // serial port phases, gray coded
   typedef enum logic [1:0] {
      CCRP_IDLE = 2'b00,
      CCRP_CMD  = 2'b01,
      CCRP_DATA = 2'b11
   } ccrp_phase_type;

endpackage : ccrp_pkg

// ===== verilog/ccrp_pin_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes inputs come from pins outside the clk domain
`timescale 1ns/1ps
`default_nettype none
module ccrp_pin_sync #(
   parameter int unsigned WIDTH = 3
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             clk_en,
   // pins in, filtered levels out
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] level_out
);

   // per bit: stage one feeds only stage two; change accepted when two and three agree
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      logic [2:0] stage;
      logic       level;
      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            stage <= 3'h0;
            level <= 1'b0;
         end else if (clk_en) begin
            stage <= {stage[1:0], pin_in[i]};
            if (stage[1] == stage[2]) begin
               level <= stage[2];
            end
         end
      end
      assign level_out[i] = level;
   end

endmodule : ccrp_pin_sync
`default_nettype wire

// ===== verification/ccrp_regs_properties.sv
// assertions on the register bank pins
// bound to ccrp_regs from the testbench top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module ccrp_regs_properties
   import ccrp_pkg::*;
(
   // clock, reset, select pin and synthesizer enable
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        spi_cs_n,
   input wire logic        synth_enable,
   // register outputs
   input wire logic [3:0]  strobe_delay_select,
   input wire logic [15:0] full_scale_range,
   input wire logic [7:0]  power_mode_code,
   input wire logic        power_low_mode,
   input wire logic        timestamp_receiver_enable,
   input wire logic        reference_clock_output
);
   logic [3:0] idle_cnt;
   // cycles since the select pin was last low, saturating
   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n) idle_cnt <= 4'hF;
      else if (!spi_cs_n) idle_cnt <= 4'h0;
      else if (idle_cnt != 4'hF) idle_cnt <= idle_cnt + 4'h1;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // first edge after release with the synthesizer on
   sequence rel_syn;
      $rose(reset_n) && synth_enable;
   endsequence
   low_mode_a: assert property (power_low_mode == (power_mode_code == POWER_LOW))
      else $error("low mode flag wrong");
   power_reset_a: assert property ($rose(reset_n) |-> power_mode_code == 8'h4B)
      else $error("power code reset wrong");
   fsr_reset_a: assert property ($rose(reset_n) |-> full_scale_range == 16'hA000)
      else $error("range reset wrong");
   timestamp_input_reset_a: assert property ($rose(reset_n) |-> !timestamp_receiver_enable)
      else $error("receiver on after reset");
   refo_reset_a: assert property (rel_syn ##1 synth_enable |=> reference_clock_output)
      else $error("ref output off after reset");
   refo_gate_a: assert property (!$past(synth_enable) |-> !reference_clock_output)
      else $error("ref output without synthesizer");
   sel_write_a: assert property (!$stable(strobe_delay_select) |-> idle_cnt < 4'hC)
      else $error("delay select changed outside a frame");
   fsr_write_a: assert property (!$stable(full_scale_range) |-> idle_cnt < 4'hC)
      else $error("range changed outside a frame");
endmodule : ccrp_regs_properties
`default_nettype wire

// ===== verification/ccrp_host_model.sv
// host side of the serial control port, behavioural
// driven by task calls from the testbench top
`timescale 1ns/1ps
`default_nettype none
module ccrp_host_model (
   // clock
   input  wire logic clk,
   // serial control port pins
   output logic      spi_sclk,
   output logic      spi_cs_n,
   output logic      spi_sdi,
   input  wire logic spi_sdo,
   input  wire logic spi_sdo_oe
);
   int half = 8;  // sclk half period in clk cycles, 6 or more for reads
   int stop_at = 0;  // nonzero: the frame is cut after this many sclk periods
   // pins idle: deselected, clock held low
   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_sdi  = 1'b0;
   end
   // one frame: read flag, address, then nb bytes most significant first
   task automatic xfer(input logic r, input logic [14:0] a, input int nb,
                       input logic [23:0] wd, output logic [23:0] rd);
      logic [15:0] c;
      int          k;
      c  = {r, a};
      rd = 24'h0;
      @(posedge clk);
      spi_cs_n <= 1'b0;
      for (k = 0; k < ((stop_at != 0) ? stop_at : 16 + 8 * nb); k++) begin
         repeat (half) @(posedge clk);
         spi_sclk <= 1'b0;
         spi_sdi  <= (k < 16) ? c[15 - k] : wd[8 * nb + 15 - k];
         repeat (half) @(posedge clk);
         if (k >= 16)
            rd = {rd[22:0], spi_sdo_oe ? spi_sdo : ~spi_sdo};  // released line shows the inverse
         spi_sclk <= 1'b1;
      end
      repeat (half) @(posedge clk);
      spi_cs_n <= 1'b1;
      repeat (2) @(posedge clk);
      spi_sclk <= 1'b0;
      repeat (8) @(posedge clk);
   endtask : xfer
endmodule : ccrp_host_model
`default_nettype wire

// ===== verification/tb.sv
// self-checking bench for the register bank
// serial traffic comes from the host model, checker bound below
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ccrp_pkg::*;
   logic        clk = 0;
   logic        reset_n = 0;
   logic        clk_en = 1;
   logic        synth_enable = 1;
   logic        strobe_window_valid = 0;
   logic [23:0] strobe_window_status = 0;
   logic        spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe;
   logic [3:0]  sel;
   logic [15:0] fsr;
   logic [7:0]  pwr, fbdiv;
   logic        low, rcv, pecl, refo;
   logic [23:0] v;
   int          n_fail = 0, total_checks = 0, seed = 69057, i;
   ccrp_regs i_ccrp_regs (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .spi_sclk(spi_sclk),
      .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
      .strobe_window_status(strobe_window_status), .strobe_window_valid(strobe_window_valid),
      .synth_enable(synth_enable), .strobe_delay_select(sel), .full_scale_range(fsr),
      .power_mode_code(pwr), .power_low_mode(low), .timestamp_receiver_enable(rcv),
      .timestamp_pecl_mode(pecl), .reference_clock_output(refo),
      .synth_feedback_divider_first(fbdiv));
   ccrp_host_model i_ccrp_host_model (.clk(clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
      .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe));
   always #5 clk = ~clk;
   // compare one value and count it
   task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // serial write, and serial read with comparison
   task automatic wr(input logic [14:0] a, input int nb, input logic [23:0] d);
      logic [23:0] x;
      i_ccrp_host_model.xfer(1'b0, a, nb, d, x);
   endtask : wr
   task automatic rdc(input string nm, input logic [14:0] a, input int nb, input logic [23:0] e);
      logic [23:0] x;
      i_ccrp_host_model.xfer(1'b1, a, nb, 24'h0, x);
      chk(nm, x, e);
   endtask : rdc
   // expected reference output level
   function automatic logic refo_of(input logic en, input logic syn);
      return en & syn;
   endfunction : refo_of
   // verdict and end of run
   task automatic finish_test;
      if (n_fail == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : finish_test
   // watchdog on the whole run
   initial begin
      repeat (60000) @(posedge clk);
      n_fail++;
      finish_test;
   end
   // main sequence
   initial begin
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      repeat (8) @(posedge clk);
      chk("refo pin", refo, 24'h1);
      rdc("pos rst", ADDR_POS_HI, 3, 24'h0);
      rdc("fsr rst", ADDR_FSR_HI, 2, 24'hA000);
      rdc("pwr rst", ADDR_POWER_FIRST, 1, 24'h4B);
      rdc("timestamp_input rst", ADDR_TIMESTAMP_INPUT_CONTROL, 1, 24'h0);
      rdc("refo rst", ADDR_REFO_CTRL, 1, 24'h1);
      // capture a random position, then try to overwrite it
      v = 24'($random(seed));
      strobe_window_status <= v;
      strobe_window_valid  <= 1'b1;
      @(posedge clk);
      strobe_window_valid  <= 1'b0;
      rdc("pos", ADDR_POS_HI, 3, v);
      wr(ADDR_POS_HI, 3, ~v);
      rdc("pos kept", ADDR_POS_HI, 3, v);
      // clock enable low freezes the capture register
      clk_en <= 1'b0;
      strobe_window_status <= ~v;
      strobe_window_valid  <= 1'b1;
      repeat (4) @(posedge clk);
      clk_en <= 1'b1;
      strobe_window_valid  <= 1'b0;
      @(posedge clk);
      rdc("pos frozen", ADDR_POS_HI, 3, v);
      // delay tap taken from the position, reserved bit left at default
      wr(ADDR_STROBE_CTRL, 1, {16'h0, 4'h8, v[3:0]});
      chk("sel", sel, v[3:0]);
      // range corners and a random legal code, prompt and slow host
      for (i = 0; i < 3; i++) begin
         i_ccrp_host_model.half = 8 + 4 * i;
         v = (i == 0) ? 24'h2000 : (i == 1) ? 24'hFFFF : {8'h0, 16'($random(seed)) | 16'h2000};
         wr(ADDR_FSR_HI, 2, v);
         chk("fsr", fsr, v);
         rdc("fsr lo", ADDR_FSR_LO, 1, v[7:0]);
      end
      // a frame cut after four data bits writes nothing
      i_ccrp_host_model.stop_at = 20;
      wr(ADDR_FSR_LO, 1, ~v);
      i_ccrp_host_model.stop_at = 0;
      chk("fsr cut", fsr, v);
      i_ccrp_host_model.half = 8;
      // both power codes; rate, companions and calibration lie with the host
      for (i = 0; i < 2; i++) begin
         v = i ? 24'h4B : 24'h46;
         wr(ADDR_POWER_FIRST, 1, v);
         chk("pwr", pwr, v);
         chk("low", low, v == 24'h46);
      end
      // receiver and pecl bits in every combination, reserved bits zero
      for (i = 0; i < 4; i++) begin
         wr(ADDR_TIMESTAMP_INPUT_CONTROL, 1, 24'(i));
         chk("rcv", rcv, i & 1);
         chk("pecl", pecl, i >> 1);
      end
      // reference output against its enable and the synthesizer
      for (i = 0; i < 4; i++) begin
         synth_enable <= i[1];
         wr(ADDR_REFO_CTRL, 1, 24'(i & 1));
         chk("refo", refo, refo_of(i[0], i[1]));
      end
      // divider byte, written and checked on its pin
      v = 24'($random(seed)) & 24'h0F;
      wr(ADDR_FBDIV_FIRST, 1, v);
      chk("fbdiv", fbdiv, v);
      // second reset near the end: pins return to their defaults, then an unmapped read
      reset_n <= 1'b0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      repeat (8) @(posedge clk);
      chk("fsr rst2", fsr, 24'hA000);
      chk("pwr rst2", pwr, 24'h4B);
      chk("rcv rst2", rcv, 24'h0);
      chk("sel rst2", sel, 24'h0);
      chk("refo rst2", refo, 24'h1);
      rdc("unmapped", 15'h007F, 1, 24'h0);
      finish_test;
   end
endmodule : tb
bind ccrp_regs ccrp_regs_properties i_props (.clk(clk), .reset_n(reset_n),
   .spi_cs_n(spi_cs_n), .synth_enable(synth_enable),
   .strobe_delay_select(strobe_delay_select), .full_scale_range(full_scale_range),
   .power_mode_code(power_mode_code), .power_low_mode(power_low_mode),
   .timestamp_receiver_enable(timestamp_receiver_enable),
   .reference_clock_output(reference_clock_output));
`default_nettype wire
